/* tmb_map.svh */
// Purpose: register indices, field positions, masks and reset values of the type B timer
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef TMB_MAP_SVH
`define TMB_MAP_SVH

`define TMB_IDX_CONTROL_A 6'h00
`define TMB_IDX_CONTROL_B 6'h01
`define TMB_IDX_EVENT_CTRL 6'h04
`define TMB_IDX_INT_ENABLE 6'h05
`define TMB_IDX_INT_FLAG 6'h06
`define TMB_IDX_STATUS 6'h07
`define TMB_IDX_COUNT 6'h0A
`define TMB_IDX_COMPARE 6'h0C

`define TMB_A_ENABLE 0
`define TMB_A_CLOCK_SOURCE_SELECT_LSB 1
`define TMB_A_RESTART 4
`define TMB_A_STANDBY 6
`define TMB_B_MODE_LSB 0
`define TMB_B_OUT_EN 4
`define TMB_B_INIT 5
`define TMB_B_UNSYNC 6
`define TMB_EV_INPUT_EN 0
`define TMB_EV_EDGE 4
`define TMB_EV_FILTER 6
`define TMB_FLAG_BIT 0

`define TMB_MASK_A 8'h57
`define TMB_MASK_B 8'h77
`define TMB_MASK_EV 8'h51
`define TMB_RST_BYTE 8'h00
`define TMB_RST_WORD 16'h0000
`define TMB_FILTER_LEN 4

`endif

/* tmb_pkg.sv */
// Purpose: types shared by the type B timer
// Assumes: nothing
// Notes: mode and clock encodings follow their select fields; the fp state encoding is internal
package tmb_pkg;
	typedef enum logic [2:0] {
		TMB_PERIODIC = 3'b000,
		TMB_TIMEOUT = 3'b001,
		TMB_CAPTURE = 3'b010,
		TMB_FREQ = 3'b011,
		TMB_PULSE = 3'b100,
		TMB_FREQ_PULSE = 3'b101,
		TMB_SINGLE = 3'b110,
		TMB_PWM8 = 3'b111
	} tmb_mode_t;
	typedef enum logic [1:0] {
		TMB_PERIPHERAL_CLOCK = 2'b00,
		TMB_CLK_HALF = 2'b01,
		TMB_CLK_COMP = 2'b10,
		TMB_CLK_RSVD = 2'b11
	} tmb_clk_t;
	typedef enum logic [1:0] {
		TMB_FP_IDLE = 2'b00,
		TMB_FP_RUN = 2'b01,
		TMB_FP_HOLD = 2'b10
	} tmb_fp_t;
endpackage

/* tmb_timer_b.sv */
// Purpose: mode, clock, event and output control of a 16-bit type B timer on APB
// Assumes: companion tick and restart come from logic on pclk; event input is asynchronous
// Notes: zero-wait APB slave, registers one word each, pslverr on unmapped address
`include "tmb_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tmb_timer_b (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic event_in,
	input wire logic companion_tick,
	input wire logic companion_restart,
	input wire logic standby_sleep,
	output logic compare_out,
	output logic event_strobe,
	output logic irq
);

////////////////////////////////////////////////////////////////////////////////

logic [7:0] ctrl_a_r, ctrl_a_nxt;
logic [7:0] ctrl_b_r, ctrl_b_nxt;
logic [7:0] ev_ctrl_r, ev_ctrl_nxt;
logic ie_r, ie_nxt;
logic flag_r, flag_nxt;
logic [15:0] cnt_r, cnt_nxt;
logic [15:0] ccmp_r, ccmp_nxt;
logic run_r, run_nxt;
logic div_r, div_nxt;
logic ss_r, ss_nxt;
tmb_pkg::tmb_fp_t fp_r, fp_nxt;
logic ev_s1_r, ev_s2_r;
logic [`TMB_FILTER_LEN-1:0] hist_r, hist_nxt;
logic filt_r, filt_nxt;
logic prev_r, prev_nxt;
logic out_r, out_nxt;
logic strobe_r, strobe_nxt;
logic irq_r, irq_nxt;
logic [31:0] prdata_r, prdata_nxt;
logic pready_r, pready_nxt;
logic pslverr_r, pslverr_nxt;

logic [5:0] idx;
logic setup, acc, wr, rd, hit;
logic [31:0] rdata;
logic en, filt_on, edge_sel, ev_en, unsync, oe, init_lvl, ksb, restart_en;
tmb_pkg::tmb_mode_t mode;
tmb_pkg::tmb_clk_t clk_sel;
logic sample, pos, neg, ev_a, ev_b;
logic tick, halt, step, top_hit, pwm_top, set, catch_event_flag, clr, sw_clear, catch_event_flag_mode;
logic [15:0] inc;

assign pready = pready_r;
assign prdata = prdata_r;
assign pslverr = pslverr_r;
assign compare_out = out_r;
assign event_strobe = strobe_r;
assign irq = irq_r;

////////////////////////////////////////////////////////////////////////////////
// field decode

assign idx = paddr[7:2];
assign setup = psel & ~penable;
assign acc = psel & penable & pready_r;
assign wr = acc & pwrite & hit;
assign rd = acc & ~pwrite & hit;
assign en = ctrl_a_r[`TMB_A_ENABLE];
assign restart_en = ctrl_a_r[`TMB_A_RESTART];
assign ksb = ctrl_a_r[`TMB_A_STANDBY];
assign clk_sel = tmb_pkg::tmb_clk_t'(ctrl_a_r[`TMB_A_CLOCK_SOURCE_SELECT_LSB+:2]);
assign mode = tmb_pkg::tmb_mode_t'(ctrl_b_r[`TMB_B_MODE_LSB+:3]);
assign oe = ctrl_b_r[`TMB_B_OUT_EN];
assign init_lvl = ctrl_b_r[`TMB_B_INIT];
assign unsync = ctrl_b_r[`TMB_B_UNSYNC];
assign ev_en = ev_ctrl_r[`TMB_EV_INPUT_EN];
assign edge_sel = ev_ctrl_r[`TMB_EV_EDGE];
assign filt_on = ev_ctrl_r[`TMB_EV_FILTER];
assign catch_event_flag_mode = (mode == tmb_pkg::TMB_CAPTURE) || (mode == tmb_pkg::TMB_FREQ) ||
	(mode == tmb_pkg::TMB_PULSE) || (mode == tmb_pkg::TMB_FREQ_PULSE);

////////////////////////////////////////////////////////////////////////////////
// apb slave: read data and error latched in setup, shown in the access cycle

always_comb begin
	rdata = 32'h0000_0000;
	hit = (paddr[1:0] == 2'b00);
	case (idx)
		`TMB_IDX_CONTROL_A: rdata = {24'h00_0000, ctrl_a_r};
		`TMB_IDX_CONTROL_B: rdata = {24'h00_0000, ctrl_b_r};
		`TMB_IDX_EVENT_CTRL: rdata = {24'h00_0000, ev_ctrl_r};
		`TMB_IDX_INT_ENABLE: rdata = {31'h0000_0000, ie_r};
		`TMB_IDX_INT_FLAG: rdata = {31'h0000_0000, flag_r};
		`TMB_IDX_STATUS: rdata = {31'h0000_0000, run_r};
		`TMB_IDX_COUNT: rdata = {16'h0000, cnt_r};
		`TMB_IDX_COMPARE: rdata = {16'h0000, ccmp_r};
		default: hit = 1'b0;
	endcase
	pready_nxt = setup;
	prdata_nxt = (setup && !pwrite) ? rdata : 32'h0000_0000;
	pslverr_nxt = setup & ~hit;
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready_r <= 1'b0;
		prdata_r <= 32'h0000_0000;
		pslverr_r <= 1'b0;
	end else begin
		pready_r <= pready_nxt;
		prdata_r <= prdata_nxt;
		pslverr_r <= pslverr_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// control registers; reserved bits are masked so they read zero

always_comb begin
	ctrl_a_nxt = ctrl_a_r;
	ctrl_b_nxt = ctrl_b_r;
	ev_ctrl_nxt = ev_ctrl_r;
	ie_nxt = ie_r;
	if (wr && idx == `TMB_IDX_CONTROL_A) begin
		ctrl_a_nxt = pwdata[7:0] & `TMB_MASK_A;
	end
	if (wr && idx == `TMB_IDX_CONTROL_B) begin
		ctrl_b_nxt = pwdata[7:0] & `TMB_MASK_B;
	end
	if (wr && idx == `TMB_IDX_EVENT_CTRL) begin
		ev_ctrl_nxt = pwdata[7:0] & `TMB_MASK_EV;
	end
	if (wr && idx == `TMB_IDX_INT_ENABLE) begin
		ie_nxt = pwdata[`TMB_FLAG_BIT];
	end
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ctrl_a_r <= `TMB_RST_BYTE;
		ctrl_b_r <= `TMB_RST_BYTE;
		ev_ctrl_r <= `TMB_RST_BYTE;
		ie_r <= 1'b0;
	end else begin
		ctrl_a_r <= ctrl_a_nxt;
		ctrl_b_r <= ctrl_b_nxt;
		ev_ctrl_r <= ev_ctrl_nxt;
		ie_r <= ie_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// event input: synchroniser, noise canceller, edge detector

always_comb begin
	hist_nxt = {hist_r[`TMB_FILTER_LEN-2:0], ev_s2_r};
	filt_nxt = filt_r;
	if (&hist_r) begin
		filt_nxt = 1'b1;
	end else if (~|hist_r) begin
		filt_nxt = 1'b0;
	end
	sample = filt_on ? filt_r : ev_s2_r;
	prev_nxt = sample;
	// edges seen while disabled are dropped, not queued
	pos = en & ev_en & sample & ~prev_r;
	neg = en & ev_en & ~sample & prev_r;
	ev_a = edge_sel ? neg : pos;
	ev_b = edge_sel ? pos : neg;
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		ev_s1_r <= 1'b0;
		ev_s2_r <= 1'b0;
		hist_r <= '0;
		filt_r <= 1'b0;
		prev_r <= 1'b0;
	end else begin
		ev_s1_r <= event_in;
		ev_s2_r <= ev_s1_r;
		hist_r <= hist_nxt;
		filt_r <= filt_nxt;
		prev_r <= prev_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// count enable: pclk, halved pclk or companion tick

always_comb begin
	div_nxt = ~div_r;
	case (clk_sel)
		tmb_pkg::TMB_PERIPHERAL_CLOCK: tick = 1'b1;
		tmb_pkg::TMB_CLK_HALF: tick = div_r;
		tmb_pkg::TMB_CLK_COMP: tick = companion_tick;
		default: tick = 1'b0;
	endcase
	// companion clock already stops with its owner in standby
	halt = standby_sleep & ~ksb & (clk_sel != tmb_pkg::TMB_CLK_COMP);
	step = tick & ~halt & en & run_r;
	top_hit = (cnt_r == ccmp_r);
	// pwm period ends on the low compare byte only
	pwm_top = (cnt_r[7:0] == ccmp_r[7:0]);
	inc = 16'(cnt_r + 16'h0001);
end

////////////////////////////////////////////////////////////////////////////////
// timer core

always_comb begin
	cnt_nxt = cnt_r;
	ccmp_nxt = ccmp_r;
	run_nxt = run_r;
	fp_nxt = fp_r;
	ss_nxt = ss_r;
	set = 1'b0;
	catch_event_flag = 1'b0;
	clr = 1'b0;
	out_nxt = init_lvl;
	if (!en) begin
		run_nxt = 1'b0;
		fp_nxt = tmb_pkg::TMB_FP_IDLE;
		ss_nxt = 1'b0;
	end else begin
		case (mode)
			tmb_pkg::TMB_PERIODIC: begin
				run_nxt = 1'b1;
				if (step) begin
					cnt_nxt = top_hit ? 16'h0000 : inc;
					set = top_hit;
				end
			end
			tmb_pkg::TMB_TIMEOUT: begin
				if (ev_a) begin
					run_nxt = 1'b1;
				end else if (ev_b) begin
					run_nxt = 1'b0;
				end
				if (step) begin
					cnt_nxt = top_hit ? 16'h0000 : inc;
					set = top_hit;
				end
			end
			tmb_pkg::TMB_CAPTURE: begin
				run_nxt = 1'b1;
				if (step) begin
					cnt_nxt = inc;
				end
				catch_event_flag = ev_a;
				set = ev_a;
			end
			tmb_pkg::TMB_FREQ: begin
				run_nxt = 1'b1;
				if (step) begin
					cnt_nxt = inc;
				end
				catch_event_flag = ev_a;
				clr = ev_a;
				set = ev_a;
			end
			tmb_pkg::TMB_PULSE: begin
				run_nxt = 1'b1;
				if (step) begin
					cnt_nxt = inc;
				end
				clr = ev_a;
				catch_event_flag = ev_b;
				set = ev_b;
			end
			tmb_pkg::TMB_FREQ_PULSE: begin
				if (step) begin
					cnt_nxt = inc;
				end
				case (fp_r)
					tmb_pkg::TMB_FP_IDLE: begin
						if (ev_a) begin
							clr = 1'b1;
							run_nxt = 1'b1;
							fp_nxt = tmb_pkg::TMB_FP_RUN;
						end
					end
					tmb_pkg::TMB_FP_RUN: begin
						if (ev_b) begin
							catch_event_flag = 1'b1;
							fp_nxt = tmb_pkg::TMB_FP_HOLD;
						end
					end
					tmb_pkg::TMB_FP_HOLD: begin
						if (ev_a) begin
							run_nxt = 1'b0;
							set = 1'b1;
							fp_nxt = tmb_pkg::TMB_FP_IDLE;
						end
					end
					default: fp_nxt = tmb_pkg::TMB_FP_IDLE;
				endcase
			end
			tmb_pkg::TMB_SINGLE: begin
				if (!run_r && (pos || (edge_sel && neg))) begin
					run_nxt = 1'b1;
					ss_nxt = unsync;
				end
				if (step) begin
					ss_nxt = 1'b1;
					cnt_nxt = top_hit ? 16'h0000 : inc;
					if (top_hit) begin
						set = 1'b1;
						run_nxt = 1'b0;
						ss_nxt = 1'b0;
					end
				end
			end
			tmb_pkg::TMB_PWM8: begin
				run_nxt = 1'b1;
				if (step) begin
					cnt_nxt = pwm_top ? 16'h0000 : inc;
					set = pwm_top;
				end
			end
			default: run_nxt = 1'b0;
		endcase
	end
	if (clr) begin
		cnt_nxt = 16'h0000;
	end
	if (restart_en && companion_restart) begin
		cnt_nxt = 16'h0000;
	end
	// software write to the count wins over internal updates
	if (wr && idx == `TMB_IDX_COUNT) begin
		cnt_nxt = pwdata[15:0];
	end
	// a capture wins over a software write to the same register
	if (catch_event_flag) begin
		ccmp_nxt = cnt_r;
	end else if (wr && idx == `TMB_IDX_COMPARE) begin
		ccmp_nxt = pwdata[15:0];
	end
	if (mode == tmb_pkg::TMB_SINGLE) begin
		out_nxt = ss_nxt;
	end else if (mode == tmb_pkg::TMB_PWM8) begin
		out_nxt = en && (cnt_nxt[7:0] < ccmp_r[15:8]);
	end
	if (!oe) begin
		out_nxt = 1'b0;
	end
	sw_clear = (wr && idx == `TMB_IDX_INT_FLAG && pwdata[`TMB_FLAG_BIT]) ||
		(rd && idx == `TMB_IDX_COMPARE && catch_event_flag_mode);
	flag_nxt = set | (flag_r & ~sw_clear);
	strobe_nxt = set;
	irq_nxt = ie_nxt & flag_nxt;
end

always_ff @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		cnt_r <= `TMB_RST_WORD;
		ccmp_r <= `TMB_RST_WORD;
		run_r <= 1'b0;
		div_r <= 1'b0;
		ss_r <= 1'b0;
		fp_r <= tmb_pkg::TMB_FP_IDLE;
		flag_r <= 1'b0;
		out_r <= 1'b0;
		strobe_r <= 1'b0;
		irq_r <= 1'b0;
	end else begin
		cnt_r <= cnt_nxt;
		ccmp_r <= ccmp_nxt;
		run_r <= run_nxt;
		div_r <= div_nxt;
		ss_r <= ss_nxt;
		fp_r <= fp_nxt;
		flag_r <= flag_nxt;
		out_r <= out_nxt;
		strobe_r <= strobe_nxt;
		irq_r <= irq_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

out_forced_low_a: assert property (!oe |=> !compare_out)
	else $error("output not low while output disabled");

init_level_a: assert property (oe && ctrl_b_r[2:0] < 3'h6 |=> compare_out == $past(init_lvl))
	else $error("output does not follow initial level");

strobe_flag_a: assert property (event_strobe |-> flag_r)
	else $error("strobe without flag");

irq_gate_a: assert property (irq |-> flag_r && ie_r)
	else $error("interrupt without enabled flag");

flag_clear_a: assert property (wr && idx == `TMB_IDX_INT_FLAG && pwdata[0] && !set |=> !flag_r)
	else $error("flag not cleared by write one");

disabled_stop_a: assert property (!en |=> !run_r ##0 $stable(cnt_r) or $past(wr))
	else $error("timer runs while disabled");

ignore_edges_a: assert property ((mode == tmb_pkg::TMB_PERIODIC || mode == tmb_pkg::TMB_PWM8)
	&& !(wr && idx == `TMB_IDX_COMPARE) |=> $stable(ccmp_r))
	else $error("edge acted on in periodic or pwm mode");

capture_a: assert property (mode == tmb_pkg::TMB_CAPTURE && ev_a |=> ccmp_r == $past(cnt_r) && flag_r)
	else $error("capture edge missed");

freq_clear_a: assert property (mode == tmb_pkg::TMB_FREQ && ev_a && !(wr && idx == `TMB_IDX_COUNT)
	|=> cnt_r == 16'h0000 && event_strobe)
	else $error("frequency edge did not restart counter");

single_unsync_a: assert property (en && oe && unsync && mode == tmb_pkg::TMB_SINGLE && !run_r
	&& (pos || (edge_sel && neg))
	|=> compare_out && run_r)
	else $error("unsynced single shot output late");

endmodule
`default_nettype wire

/* tmb_event_chan.sv */
// Purpose: event channel model feeding the timer event input and watching the compare pin
// Assumes: levels change just after a rising edge of pclk
// Notes: every level is held whole cycles so the input synchroniser cannot miss it
`timescale 1ns/10ps
`default_nettype none

module tmb_event_chan (
	input wire logic pclk,
	input wire logic compare_out,
	output var logic event_in
);
	int n_high;

	initial begin
		event_in = 1'b0;
		n_high = 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin watch, handy when judging single-shot pulse length
	always @(posedge pclk) begin
		if (compare_out === 1'b1) n_high++;
	end

	// hold below three cycles only to test the noise canceller on purpose
	task automatic put(input logic v, input int hold);
		@(posedge pclk);
		event_in <= v;
		repeat (hold) @(posedge pclk);
	endtask
endmodule

`default_nettype wire

/* timer_b_mode_control_tb_top.sv */
// Purpose: self-checking bench for the type B timer control block
// Assumes: zero-wait APB slave and event latency as handed over
// Notes: counter steps are judged from two back-to-back reads, three cycles apart
`include "tmb_map.svh"
`timescale 1ns/10ps
`default_nettype none

module timer_b_mode_control_tb_top;
	localparam logic [5:0] ia = `TMB_IDX_CONTROL_A;
	localparam logic [5:0] ib = `TMB_IDX_CONTROL_B;
	localparam logic [5:0] iev = `TMB_IDX_EVENT_CTRL;
	localparam logic [5:0] iie = `TMB_IDX_INT_ENABLE;
	localparam logic [5:0] ifl = `TMB_IDX_INT_FLAG;
	localparam logic [5:0] icnt = `TMB_IDX_COUNT;
	localparam logic [5:0] icmp = `TMB_IDX_COMPARE;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic companion_tick = 1'b0;
	logic companion_restart = 1'b0;
	logic standby_sleep = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, event_in, compare_out, event_strobe, irq;
	logic [31:0] q, a;
	logic e;
	int n_fail = 0;
	int checks = 0;
	int n_strobe = 0;
	int s;

	tmb_timer_b tmb_timer_b_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in(event_in), .companion_tick(companion_tick),
		.companion_restart(companion_restart), .standby_sleep(standby_sleep),
		.compare_out(compare_out), .event_strobe(event_strobe), .irq(irq));
	tmb_event_chan tmb_event_chan_inst (.pclk(pclk), .compare_out(compare_out),
		.event_in(event_in));

	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		if (event_strobe === 1'b1) n_strobe++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// a missing pready counts as a mismatch rather than hanging the run
	task automatic apb(input logic [5:0] idx, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		if (n == 50) n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		apb(idx, 1'b1, {16'h0000, d});
	endtask

	task automatic rd(input logic [5:0] idx);
		apb(idx, 1'b0, 32'h0000_0000);
	endtask

	// disable first so mode and count changes never race a running counter
	task automatic setup(input logic [15:0] cmp, input logic [7:0] b, input logic [7:0] ev,
		input logic [7:0] av);
		wr(ia, 16'h0000);
		wr(ifl, 16'h0001);
		wr(icmp, cmp);
		wr(icnt, 16'h0000);
		wr(ib, {8'h00, b});
		wr(iev, {8'h00, ev});
		wr(ia, {8'h00, av});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [5:0] ix [5] = '{ia, ib, iev, iie, ifl};
		foreach (ix[i]) begin
			rd(ix[i]);
			chk("reset value", 32'h0000_0000, q);
		end
		chk("pin at reset", 32'h0000_0000, compare_out);
		rd(6'h08);
		chk("unmapped error", 32'h0000_0001, e);
	endtask

	task automatic t_fields();
		wr(ia, 16'h00FF);
		rd(ia);
		chk("control a", 32'h0000_0057, q);
		wr(ia, 16'h0000);
		wr(iev, 16'h00FF);
		rd(iev);
		chk("event control", 32'h0000_0051, q);
		for (int m = 0; m < 8; m++) begin
			wr(ib, {8'h00, 5'h1F, 3'(m)});
			rd(ib);
			chk("mode field", {24'h0000_00, 5'h0E, 3'(m)}, q);
		end
	endtask

	task automatic t_output();
		logic [7:0] bv [3] = '{8'h20, 8'h30, 8'h10};
		logic [2:0] ov = 3'b010;
		for (int i = 0; i < 3; i++) begin
			wr(ib, {8'h00, bv[i]});
			repeat (2) @(posedge pclk);
			chk("pin level", 32'(ov[i]), compare_out);
		end
	endtask

	task automatic t_capture(input logic sel);
		setup(16'hFFFF, 8'h02, sel ? 8'h11 : 8'h01, 8'h01);
		s = n_strobe;
		tmb_event_chan_inst.put(1'b1, 8);
		chk("rise strobes", sel ? 0 : 1, n_strobe - s);
		tmb_event_chan_inst.put(1'b0, 8);
		chk("fall strobes", 1, n_strobe - s);
		chk("irq set", 1, irq);
		if (sel) wr(ifl, 16'h0001);
		else rd(icmp);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 0, irq);
	endtask

	task automatic t_ignored();
		logic [7:0] av [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
		logic [7:0] bv [4] = '{8'h02, 8'h02, 8'h00, 8'h07};
		logic [7:0] ev [4] = '{8'h01, 8'h00, 8'h01, 8'h11};
		for (int i = 0; i < 4; i++) begin
			setup(16'hFFFF, bv[i], ev[i], av[i]);
			s = n_strobe;
			tmb_event_chan_inst.put(1'b1, 8);
			tmb_event_chan_inst.put(1'b0, 8);
			chk("ignored strobes", 0, n_strobe - s);
		end
	endtask

	// a three-cycle glitch passes the synchroniser but not four equal samples
	task automatic t_filter();
		setup(16'hFFFF, 8'h02, 8'h41, 8'h01);
		s = n_strobe;
		tmb_event_chan_inst.put(1'b1, 2);
		tmb_event_chan_inst.put(1'b0, 8);
		chk("glitch strobes", 0, n_strobe - s);
		tmb_event_chan_inst.put(1'b1, 10);
		chk("filtered strobes", 1, n_strobe - s);
		tmb_event_chan_inst.put(1'b0, 10);
	endtask

	task automatic t_count();
		logic [7:0] av [8] = '{8'h01, 8'h00, 8'h07, 8'h03, 8'h01, 8'h41, 8'h05, 8'h05};
		logic [7:0] sbv = 8'hF0;
		logic [7:0] tkv = 8'h40;
		int lo [8] = '{3, 0, 0, 1, 0, 3, 3, 0};
		int hi [8] = '{3, 0, 0, 2, 0, 3, 3, 0};
		setup(16'hFFFF, 8'h00, 8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			standby_sleep <= sbv[i];
			companion_tick <= tkv[i];
			wr(ia, {8'h00, av[i]});
			rd(icnt);
			a = q;
			rd(icnt);
			chk("count step", 1, (q - a) >= lo[i] && (q - a) <= hi[i]);
		end
		standby_sleep <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			wr(ia, 16'h0000);
			wr(icnt, 16'h8000);
			wr(ia, i ? 16'h0011 : 16'h0001);
			@(posedge pclk);
			companion_restart <= 1'b1;
			@(posedge pclk);
			companion_restart <= 1'b0;
			rd(icnt);
			chk("restarted", 32'(i), q < 32'h0000_0040);
		end
	endtask

	task automatic t_single();
		for (int i = 0; i < 2; i++) begin
			setup(16'h0014, i ? 8'h56 : 8'h16, i ? 8'h11 : 8'h01, 8'h01);
			tmb_event_chan_inst.put(i ? 1'b0 : 1'b1, 8);
			chk("shot high", 1, compare_out);
			repeat (30) @(posedge pclk);
			chk("shot low", 0, compare_out);
			chk("shot irq", 1, irq);
		end
	endtask

	task automatic t_measure();
		logic [7:0] mv [3] = '{8'h04, 8'h03, 8'h05};
		int ex [3] = '{30, 40, 20};
		for (int i = 0; i < 3; i++) begin
			setup(16'hFFFF, mv[i], 8'h01, 8'h01);
			tmb_event_chan_inst.put(1'b1, 20);
			tmb_event_chan_inst.put(1'b0, 20);
			tmb_event_chan_inst.put(1'b1, 30);
			tmb_event_chan_inst.put(1'b0, 8);
			chk("measure irq", 1, irq);
			rd(icmp);
			chk("measured", 1, q >= ex[i] - 3 && q <= ex[i] + 3);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// whole sequence needs about a thousand cycles; twenty thousand means a hang
	initial begin
		#(100 * 20000);
		n_fail++;
		results();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_fields();
		t_output();
		wr(iie, 16'h0001);
		t_capture(1'b0);
		t_capture(1'b1);
		t_ignored();
		t_filter();
		t_count();
		t_single();
		t_measure();
		results();
	end
endmodule

`default_nettype wire
